// ---- rtl/mop_supervisor.sv ----
// Motor overload supervisor with alert, fault timing and thermal model.
//
// Behaviour
// - Overload alert appears only while the alert enable is set.
// - Alert rises after current stays above alert threshold for its duration.
// - The alert never blocks or slows the drive output.
// - Relay and transistor outputs carry the alert only when set to code 5.
// - Overload fault action: 0 nothing, 1 coast, 2 decelerate to stop.
// - Overload fault after current stays above fault threshold for duration.
// - Thermal fault action: 0 disabled, 1 coast, 2 decelerate to stop.
// - A thermal trip shows its own fault status to the display.
// - One-minute rating is the current tolerated for one minute.
// - Below the continuous rating the motor runs without thermal action.
// - Cooling type: 0 shaft fan speed dependent, 1 separate fan.
// - Duty class caps one-minute tolerance: normal 120, heavy 150 percent.
`timescale 1ns/10ps
`default_nettype none
module mop_supervisor #(
    parameter int unsigned TICK_CYCLES = mop_pkg::TICK_CYCLES,
    parameter int unsigned HEAT_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] motor_current_i,
    input wire logic [7:0] motor_speed_i,
    output logic overload_alert_o,
    output logic relay_out_o,
    output logic transistor_output_one_o,
    output logic overload_fault_o,
    output logic thermal_fault_o,
    output logic output_block_o,
    output logic decel_stop_o
);

    // ************************************************************
    // Helpers.
    // ************************************************************
    function automatic logic f_is_coast(input logic [1:0] act);
        f_is_coast = (act == mop_pkg::ACT_COAST);
    endfunction

    function automatic logic f_is_decel(input logic [1:0] act);
        f_is_decel = (act == mop_pkg::ACT_DECEL);
    endfunction

    function automatic logic [7:0] f_min(input logic [7:0] a,
                                         input logic [7:0] b);
        f_min = (a < b) ? a : b;
    endfunction

    // ************************************************************
    // Settings registers and bus slave.
    // ************************************************************
    logic alert_en_q, alert_en_d;
    logic [1:0] ol_act_q, ol_act_d;
    logic [1:0] th_act_q, th_act_d;
    logic cooling_q, cooling_d;
    logic duty_q, duty_d;
    logic [3:0] relay_func_q, relay_func_d;
    logic [3:0] trans_func_q, trans_func_d;
    logic [7:0] alert_thr_q, alert_thr_d;
    logic [9:0] alert_dur_q, alert_dur_d;
    logic [7:0] fault_thr_q, fault_thr_d;
    logic [9:0] fault_dur_q, fault_dur_d;
    logic [7:0] one_min_q, one_min_d;
    logic [7:0] cont_q, cont_d;
    logic clr_ol, clr_th;
    logic [31:0] rdata_d;
    logic pready_d, pslverr_d;
    logic wr_en;
    logic mapped;
    mop_pkg::mop_apb_e apb_q, apb_d;

    // A write lands only at the edge that completes the access phase.
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;
    assign mapped = (paddr_i <= mop_pkg::CLEAR_OFS) && (paddr_i[1:0] == 2'h0);
    assign clr_ol = wr_en && (paddr_i == mop_pkg::CLEAR_OFS) &&
        pwdata_i[mop_pkg::CLR_OL_POS];
    assign clr_th = wr_en && (paddr_i == mop_pkg::CLEAR_OFS) &&
        pwdata_i[mop_pkg::CLR_TH_POS];

    // Settings update, read mux and zero-wait answer in the access phase.
    always_comb begin
        alert_en_d = alert_en_q;
        ol_act_d = ol_act_q;
        th_act_d = th_act_q;
        cooling_d = cooling_q;
        duty_d = duty_q;
        relay_func_d = relay_func_q;
        trans_func_d = trans_func_q;
        alert_thr_d = alert_thr_q;
        alert_dur_d = alert_dur_q;
        fault_thr_d = fault_thr_q;
        fault_dur_d = fault_dur_q;
        one_min_d = one_min_q;
        cont_d = cont_q;
        rdata_d = prdata_o;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        apb_d = mop_pkg::MOP_ST_IDLE;
        case (apb_q)
            mop_pkg::MOP_ST_IDLE: begin
                if (psel_i && !penable_i) begin
                    apb_d = mop_pkg::MOP_ST_ACCESS;
                    pready_d = 1'b1;
                    pslverr_d = !mapped;
                    rdata_d = 32'h0000_0000;
                    case (paddr_i)
                        mop_pkg::CTRL_OFS: begin
                            rdata_d[mop_pkg::CTRL_ALERT_EN_POS] = alert_en_q;
                            rdata_d[mop_pkg::CTRL_OL_ACT_POS+:2] = ol_act_q;
                            rdata_d[mop_pkg::CTRL_TH_ACT_POS+:2] = th_act_q;
                            rdata_d[mop_pkg::CTRL_COOLING_POS] = cooling_q;
                            rdata_d[mop_pkg::CTRL_DUTY_POS] = duty_q;
                        end
                        mop_pkg::ROUTE_OFS: begin
                            rdata_d[mop_pkg::ROUTE_RELAY_POS+:4] = relay_func_q;
                            rdata_d[mop_pkg::ROUTE_TRANS_POS+:4] = trans_func_q;
                        end
                        mop_pkg::ALERT_OFS: begin
                            rdata_d[mop_pkg::THR_POS+:8] = alert_thr_q;
                            rdata_d[mop_pkg::DUR_POS+:10] = alert_dur_q;
                        end
                        mop_pkg::FAULT_OFS: begin
                            rdata_d[mop_pkg::THR_POS+:8] = fault_thr_q;
                            rdata_d[mop_pkg::DUR_POS+:10] = fault_dur_q;
                        end
                        mop_pkg::THERM_OFS: begin
                            rdata_d[mop_pkg::THERM_ONE_MIN_POS+:8] = one_min_q;
                            rdata_d[mop_pkg::THERM_CONT_POS+:8] = cont_q;
                        end
                        mop_pkg::STATUS_OFS: begin
                            rdata_d[6:0] = {decel_stop_o, output_block_o,
                                thermal_fault_o, overload_fault_o,
                                transistor_output_one_o, relay_out_o,
                                overload_alert_o};
                        end
                        default: begin
                            rdata_d = 32'h0000_0000;
                        end
                    endcase
                end
            end
            mop_pkg::MOP_ST_ACCESS: begin
                if (wr_en) begin
                    case (paddr_i)
                        mop_pkg::CTRL_OFS: begin
                            alert_en_d = pwdata_i[mop_pkg::CTRL_ALERT_EN_POS];
                            ol_act_d = pwdata_i[mop_pkg::CTRL_OL_ACT_POS+:2];
                            th_act_d = pwdata_i[mop_pkg::CTRL_TH_ACT_POS+:2];
                            cooling_d = pwdata_i[mop_pkg::CTRL_COOLING_POS];
                            duty_d = pwdata_i[mop_pkg::CTRL_DUTY_POS];
                        end
                        mop_pkg::ROUTE_OFS: begin
                            relay_func_d =
                                pwdata_i[mop_pkg::ROUTE_RELAY_POS+:4];
                            trans_func_d =
                                pwdata_i[mop_pkg::ROUTE_TRANS_POS+:4];
                        end
                        mop_pkg::ALERT_OFS: begin
                            alert_thr_d = pwdata_i[mop_pkg::THR_POS+:8];
                            alert_dur_d = pwdata_i[mop_pkg::DUR_POS+:10];
                        end
                        mop_pkg::FAULT_OFS: begin
                            fault_thr_d = pwdata_i[mop_pkg::THR_POS+:8];
                            fault_dur_d = pwdata_i[mop_pkg::DUR_POS+:10];
                        end
                        mop_pkg::THERM_OFS: begin
                            one_min_d = pwdata_i[mop_pkg::THERM_ONE_MIN_POS+:8];
                            cont_d = pwdata_i[mop_pkg::THERM_CONT_POS+:8];
                        end
                        default: begin
                            alert_en_d = alert_en_q;
                        end
                    endcase
                end
            end
            default: begin
                apb_d = mop_pkg::MOP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            apb_q <= mop_pkg::MOP_ST_IDLE;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            alert_en_q <= mop_pkg::ALERT_EN_RST;
            ol_act_q <= mop_pkg::OL_ACT_RST;
            th_act_q <= mop_pkg::TH_ACT_RST;
            cooling_q <= mop_pkg::COOLING_RST;
            duty_q <= mop_pkg::DUTY_RST;
            relay_func_q <= mop_pkg::FUNC_RST;
            trans_func_q <= mop_pkg::FUNC_RST;
            alert_thr_q <= mop_pkg::ALERT_THR_RST;
            alert_dur_q <= mop_pkg::ALERT_DUR_RST;
            fault_thr_q <= mop_pkg::FAULT_THR_RST;
            fault_dur_q <= mop_pkg::FAULT_DUR_RST;
            one_min_q <= mop_pkg::ONE_MIN_RST;
            cont_q <= mop_pkg::CONT_RST;
        end else begin
            apb_q <= apb_d;
            prdata_o <= rdata_d;
            pready_o <= pready_d;
            pslverr_o <= pslverr_d;
            alert_en_q <= alert_en_d;
            ol_act_q <= ol_act_d;
            th_act_q <= th_act_d;
            cooling_q <= cooling_d;
            duty_q <= duty_d;
            relay_func_q <= relay_func_d;
            trans_func_q <= trans_func_d;
            alert_thr_q <= alert_thr_d;
            alert_dur_q <= alert_dur_d;
            fault_thr_q <= fault_thr_d;
            fault_dur_q <= fault_dur_d;
            one_min_q <= one_min_d;
            cont_q <= cont_d;
        end
    end

    // ************************************************************
    // Time base and threshold timers.
    // ************************************************************
    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic tick;
    logic alert_expired, fault_expired;

    // Tenth-of-second tick shared by both timers and the heat model.
    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    always_comb begin
        tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    mop_duration_timer #(.DUR_W(10)) u_alert_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .above_i(motor_current_i > alert_thr_q),
        .duration_i(alert_dur_q),
        .expired_o(alert_expired)
    );

    mop_duration_timer #(.DUR_W(10)) u_fault_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .above_i(motor_current_i > fault_thr_q),
        .duration_i(fault_dur_q),
        .expired_o(fault_expired)
    );

    // ************************************************************
    // Electronic thermal model.
    // ************************************************************
    logic [HEAT_W-1:0] heat_q, heat_d;
    logic [HEAT_W-1:0] heat_limit;
    logic [7:0] one_min_eff;
    logic [7:0] excess;
    logic heat_trip;

    // Duty class caps the tolerated one-minute current.
    assign one_min_eff = f_min(one_min_q, duty_q ?
        mop_pkg::HEAVY_DUTY_PCT : mop_pkg::NORMAL_DUTY_PCT);
    // Sized so a steady one-minute current reaches the limit in a minute.
    assign heat_limit = (one_min_eff > cont_q) ?
        HEAT_W'(one_min_eff - cont_q) * HEAT_W'(mop_pkg::ONE_MINUTE_TICKS)
        : HEAT_W'(1);
    assign excess = (motor_current_i > cont_q) ?
        motor_current_i - cont_q : 8'h00;
    assign heat_trip = (heat_q >= heat_limit);

    // A shaft fan cools poorly at low speed, so heat builds twice as fast.
    // Heat stops rising at the limit, so a long overload cannot wrap it.
    always_comb begin
        heat_d = heat_q;
        if (tick) begin
            if (excess != 8'h00) begin
                if (heat_trip) begin
                    heat_d = heat_q;
                end else if (!cooling_q &&
                             (motor_speed_i < mop_pkg::LOW_SPEED_PCT)) begin
                    heat_d = heat_q + HEAT_W'({excess, 1'b0});
                end else begin
                    heat_d = heat_q + HEAT_W'(excess);
                end
            end else if (heat_q != '0) begin
                heat_d = heat_q - HEAT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            heat_q <= '0;
        end else begin
            heat_q <= heat_d;
        end
    end

    // ************************************************************
    // Alert routing and fault latches.
    // ************************************************************
    logic alert_d, relay_d, trans_d;
    logic ol_fault_d, th_fault_d, block_d, decel_d;

    // Faults hold until cleared; a new trip in the clear cycle wins.
    always_comb begin
        alert_d = alert_en_q && alert_expired;
        relay_d = alert_d && (relay_func_q == mop_pkg::FUNC_OVERLOAD);
        trans_d = alert_d && (trans_func_q == mop_pkg::FUNC_OVERLOAD);
        ol_fault_d = (fault_expired && (ol_act_q != mop_pkg::ACT_NONE)) ||
            (overload_fault_o && !clr_ol);
        th_fault_d = (heat_trip && (th_act_q != mop_pkg::ACT_NONE)) ||
            (thermal_fault_o && !clr_th);
        block_d = (ol_fault_d && f_is_coast(ol_act_q)) ||
            (th_fault_d && f_is_coast(th_act_q));
        decel_d = !block_d && ((ol_fault_d && f_is_decel(ol_act_q)) ||
            (th_fault_d && f_is_decel(th_act_q)));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overload_alert_o <= 1'b0;
            relay_out_o <= 1'b0;
            transistor_output_one_o <= 1'b0;
            overload_fault_o <= 1'b0;
            thermal_fault_o <= 1'b0;
            output_block_o <= 1'b0;
            decel_stop_o <= 1'b0;
        end else begin
            overload_alert_o <= alert_d;
            relay_out_o <= relay_d;
            transistor_output_one_o <= trans_d;
            overload_fault_o <= ol_fault_d;
            thermal_fault_o <= th_fault_d;
            output_block_o <= block_d;
            decel_stop_o <= decel_d;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_alert_needs_enable: assert property (
        overload_alert_o |-> $past(alert_en_q))
        else $error("Alert raised while alert enable was clear.");
    a_alert_timed: assert property (
        $rose(overload_alert_o) |-> $past(alert_expired))
        else $error("Alert rose before its duration elapsed.");
    a_alert_no_block: assert property (
        (output_block_o || decel_stop_o) |->
        (overload_fault_o || thermal_fault_o))
        else $error("Drive output stopped without a fault.");
    a_route_relay: assert property (
        relay_out_o |-> overload_alert_o &&
        ($past(relay_func_q) == mop_pkg::FUNC_OVERLOAD))
        else $error("Relay carried alert without overload function.");
    a_ol_coast: assert property (
        overload_fault_o && $past(f_is_coast(ol_act_q)) |-> output_block_o)
        else $error("Overload fault with coast action did not block.");
    a_ol_trip_timed: assert property (
        $rose(overload_fault_o) |-> $past(fault_expired) &&
        ($past(ol_act_q) != mop_pkg::ACT_NONE))
        else $error("Overload fault without expired trip timer.");
    a_th_disabled: assert property (
        $rose(thermal_fault_o) |-> ($past(th_act_q) != mop_pkg::ACT_NONE))
        else $error("Thermal fault raised while thermal action is off.");
    a_th_status: assert property (
        $rose(thermal_fault_o) |-> $past(heat_trip))
        else $error("Thermal fault status without heat trip.");
    a_heat_rises: assert property (
        tick && (excess != 8'h00) && !heat_trip |=>
        (heat_q > $past(heat_q)))
        else $error("Heat did not rise above continuous rating.");
    a_heat_cools: assert property (
        tick && (excess == 8'h00) && (heat_q != '0) |=>
        (heat_q == $past(heat_q) - HEAT_W'(1)))
        else $error("Heat did not fall below continuous rating.");

    c_alert: cover property ($rose(overload_alert_o));
    c_ol_fault: cover property ($rose(overload_fault_o));
    c_th_fault: cover property ($rose(thermal_fault_o));
    c_apb_write: cover property (wr_en);

endmodule
`default_nettype wire

// ---- rtl/mop_pkg.sv ----
// Constants shared by the motor overload protection block.
package mop_pkg;

    // ************************************************************
    // Time base and timing counts.
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 25;
    // One step of every duration setting is a tenth of a second.
    localparam int unsigned TICK_NS = 100_000_000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // A minute in nanoseconds overflows 32 bits, so count in seconds.
    localparam int unsigned SECOND_NS = 1_000_000_000;
    localparam int unsigned ONE_MINUTE_TICKS = 60 * (SECOND_NS / TICK_NS);

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ROUTE_OFS = 8'h04;
    localparam logic [7:0] ALERT_OFS = 8'h08;
    localparam logic [7:0] FAULT_OFS = 8'h0c;
    localparam logic [7:0] THERM_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] CLEAR_OFS = 8'h18;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int unsigned CTRL_ALERT_EN_POS = 0;
    localparam int unsigned CTRL_OL_ACT_POS = 1;
    localparam int unsigned CTRL_TH_ACT_POS = 3;
    localparam int unsigned CTRL_COOLING_POS = 5;
    localparam int unsigned CTRL_DUTY_POS = 6;
    localparam int unsigned ROUTE_RELAY_POS = 0;
    localparam int unsigned ROUTE_TRANS_POS = 4;
    localparam int unsigned THR_POS = 0;
    localparam int unsigned DUR_POS = 16;
    localparam int unsigned THERM_ONE_MIN_POS = 0;
    localparam int unsigned THERM_CONT_POS = 8;
    localparam int unsigned CLR_OL_POS = 0;
    localparam int unsigned CLR_TH_POS = 1;

    // ************************************************************
    // Reset values and codes.
    // ************************************************************
    localparam logic ALERT_EN_RST = 1'b1;
    localparam logic [1:0] OL_ACT_RST = 2'h1;
    localparam logic [1:0] TH_ACT_RST = 2'h0;
    localparam logic COOLING_RST = 1'b0;
    localparam logic DUTY_RST = 1'b1;
    localparam logic [3:0] FUNC_OVERLOAD = 4'h5;
    localparam logic [3:0] FUNC_RST = 4'h5;
    localparam logic [7:0] ALERT_THR_RST = 8'h96;
    localparam logic [9:0] ALERT_DUR_RST = 10'h064;
    localparam logic [7:0] FAULT_THR_RST = 8'hb4;
    localparam logic [9:0] FAULT_DUR_RST = 10'h258;
    localparam logic [7:0] ONE_MIN_RST = 8'h96;
    localparam logic [7:0] CONT_RST = 8'h78;
    localparam logic [7:0] NORMAL_DUTY_PCT = 8'h78;
    localparam logic [7:0] HEAVY_DUTY_PCT = 8'h96;
    localparam logic [7:0] LOW_SPEED_PCT = 8'h32;

    // Fault action codes.
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_COAST = 2'h1;
    localparam logic [1:0] ACT_DECEL = 2'h2;

    typedef enum logic {MOP_ST_IDLE, MOP_ST_ACCESS} mop_apb_e;

endpackage

// ---- rtl/mop_duration_timer.sv ----
// Counts how long a level stays above a threshold, in time-base ticks.
`timescale 1ns/10ps
`default_nettype none
module mop_duration_timer #(
    parameter int unsigned DUR_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic above_i,
    input wire logic [DUR_W-1:0] duration_i,
    output logic expired_o
);

    logic [DUR_W-1:0] cnt_q;
    logic [DUR_W-1:0] cnt_d;

    // The count restarts from zero whenever the level drops back, so
    // only an unbroken excursion ever reaches the duration.
    always_comb begin
        cnt_d = cnt_q;
        if (!above_i) begin
            cnt_d = '0;
        end else if (tick_i && (cnt_q < duration_i)) begin
            cnt_d = cnt_q + DUR_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // A zero duration expires at the first cycle above the threshold.
    assign expired_o = above_i && (cnt_q >= duration_i);

    // ************************************************************
    // Assertions.
    // ************************************************************
    a_count_restarts: assert property (@(posedge clk_i) disable iff (rst_i)
        !above_i |=> (cnt_q == '0))
        else $error("Duration count kept after level dropped.");
    a_count_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
        above_i && tick_i && (cnt_q < duration_i) && $stable(duration_i)
        |=> above_i |-> (cnt_q == $past(cnt_q) + DUR_W'(1)))
        else $error("Duration count did not advance on a tick.");

endmodule
`default_nettype wire

// ---- sim/mop_motor_model.sv ----
// Behavioural model of the motor current sensing and drive output stage.
`timescale 1ns/10ps
`default_nettype none
module mop_motor_model (
    input wire logic clk_i,
    input wire logic [7:0] load_pct_i,
    input wire logic output_block_i,
    input wire logic decel_stop_i,
    output logic [7:0] motor_current_o,
    output logic [7:0] motor_speed_o
);
    // Outputs start at known levels so the design never sees an unknown.
    initial begin
        motor_current_o = 8'h00;
        motor_speed_o = 8'h64;
    end

    // A blocked stage carries no current; a stop command ramps speed down.
    always @(posedge clk_i) begin
        motor_current_o <= output_block_i ? 8'h00 : load_pct_i;
        if (output_block_i || decel_stop_i) begin
            motor_speed_o <= (motor_speed_o != 8'h00) ?
                motor_speed_o - 8'h01 : 8'h00;
        end else begin
            motor_speed_o <= 8'h64;
        end
    end
endmodule
`default_nettype wire

// ---- sim/mop_supervisor_tb.sv ----
// Self-checking testbench for the motor overload supervisor.
`timescale 1ns/10ps
`default_nettype none
module mop_supervisor_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, load, cur, spd;
    logic [31:0] pwdata, prdata, rd;
    logic alert, relay, trans, olf, thf, blk, dec;
    logic [2:0] ex;
    int miscompares = 0;
    int num_checks = 0;

    // A short tick keeps the tenth-second counts quick to simulate.
    mop_supervisor #(.TICK_CYCLES(4)) dut_u (.clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .motor_current_i(cur),
        .motor_speed_i(spd), .overload_alert_o(alert), .relay_out_o(relay),
        .transistor_output_one_o(trans), .overload_fault_o(olf),
        .thermal_fault_o(thf), .output_block_o(blk), .decel_stop_o(dec));
    mop_motor_model model_u (.clk_i(clk), .load_pct_i(load),
        .output_block_i(blk), .decel_stop_i(dec), .motor_current_o(cur),
        .motor_speed_o(spd));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high, and
    // an idle edge follows so no signal is assigned twice in one step.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog: the sequence needs about six hundred cycles.
    initial begin
        #(25 * 8000);
        miscompares++;
        print_verdict();
    end

    // Main sequence: reset values, alert path, fault actions, thermal trip.
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        load = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, mop_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_0043);
        apb(1'b0, mop_pkg::ALERT_OFS, 32'h0);
        chk(rd, 32'h0064_0096);
        apb(1'b0, mop_pkg::THERM_OFS, 32'h0);
        chk(rd, 32'h0000_7896);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, mop_pkg::ALERT_OFS, 32'h0002_0064);
        apb(1'b1, mop_pkg::FAULT_OFS, 32'h0258_00c8);
        load <= 8'h78;
        repeat (20) @(posedge clk);
        chk({alert, relay, trans, blk}, 32'he);
        apb(1'b1, mop_pkg::ROUTE_OFS, 32'h50);
        repeat (2) @(posedge clk);
        chk({relay, trans}, 32'h1);
        load <= 8'h64;
        repeat (4) @(posedge clk);
        chk(alert, 32'h0);
        load <= 8'h78;
        repeat (6) @(posedge clk);
        chk(alert, 32'h0);
        repeat (14) @(posedge clk);
        chk(alert, 32'h1);
        apb(1'b1, mop_pkg::CTRL_OFS, 32'h42);
        repeat (2) @(posedge clk);
        chk(alert, 32'h0);
        // Each overload action code in turn, cleared after every trip.
        for (int i = 0; i < 3; i++) begin
            ex = (i == 0) ? 3'b000 : ((i == 1) ? 3'b110 : 3'b101);
            apb(1'b1, mop_pkg::CTRL_OFS, 32'h40 | (i << 1));
            apb(1'b1, mop_pkg::FAULT_OFS, 32'h0001_0082);
            load <= 8'h96;
            repeat (16) @(posedge clk);
            chk({olf, blk, dec}, {29'h0, ex});
            load <= 8'h00;
            apb(1'b0, mop_pkg::STATUS_OFS, 32'h0);
            chk(rd[6:3], {28'h0, ex[0], ex[1], 1'b0, ex[2]});
            apb(1'b1, mop_pkg::CLEAR_OFS, 32'h1);
        end
        // Heavy duty caps the rating at 150; limit is (150-144)*600 heat.
        apb(1'b1, mop_pkg::THERM_OFS, 32'h0000_90c8);
        apb(1'b1, mop_pkg::CTRL_OFS, 32'h68);
        apb(1'b0, mop_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_0068);
        load <= 8'hc8;
        repeat (150) @(posedge clk);
        chk({thf, blk}, 32'h0);
        repeat (250) @(posedge clk);
        chk({thf, blk}, 32'h3);
        print_verdict();
    end
endmodule
`default_nettype wire
